// file: crc_fault_inject.v
`timescale 1ns/1ps
`default_nettype none
`include "sink_port_defs.vh"

module crc_fault_inject (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire inject_pin,
    input wire inject_sw,
    input wire tx_crc_valid,
    input wire [`CRC_W-1:0] tx_crc_in,
    output reg tx_crc_out_valid,
    output reg [`CRC_W-1:0] tx_crc_out,
    output wire inject_pending
);

// ==========================================================
// Pin synchroniser and edge detect
reg pin_meta_ff;
reg pin_sync_ff;
reg pin_last_ff;
reg armed_ff;
wire arm_req;

assign arm_req = (pin_sync_ff & ~pin_last_ff) | inject_sw;
assign inject_pending = armed_ff;

always @(posedge aclk) begin
    if (!aresetn) begin
        pin_meta_ff <= 1'b0;
        pin_sync_ff <= 1'b0;
        pin_last_ff <= 1'b0;
    end else if (ce) begin
        pin_meta_ff <= inject_pin;
        pin_sync_ff <= pin_meta_ff;
        pin_last_ff <= pin_sync_ff;
    end
end

// ==========================================================
// Corrupt the next outgoing CRC once per request
always @(posedge aclk) begin
    if (!aresetn) begin
        armed_ff <= 1'b0;
        tx_crc_out_valid <= 1'b0;
        tx_crc_out <= {`CRC_W{1'b0}};
    end else if (ce) begin
        tx_crc_out_valid <= tx_crc_valid;
        if (tx_crc_valid && armed_ff) begin
            tx_crc_out <= tx_crc_in ^ `CRC_FLIP;
        end else begin
            tx_crc_out <= tx_crc_in;
        end
        // A new request in the consuming cycle keeps the arm set.
        if (arm_req) begin
            armed_ff <= 1'b1;
        end else if (tx_crc_valid) begin
            armed_ff <= 1'b0;
        end
    end
end

endmodule

`default_nettype wire

// file: sink_port_defs.vh
`ifndef SINK_PORT_DEFS_VH
`define SINK_PORT_DEFS_VH

// ==========================================================
// Link geometry
`define LANES 2
`define LANE_W 64
`define DATA_W (`LANES * `LANE_W)
`define SYNC_W 8
`define ERR_W (`LANES + 5)
`define ERR_ALIGN (`LANES)
`define ERR_ZERO (`LANES + 1)
`define ERR_OVF (`LANES + 2)
`define ERR_ECC_FIX (`LANES + 3)
`define ERR_ECC_BAD (`LANES + 4)
`define CRC_W 32
`define CRC_FLIP 32'hFFFFFFFF

// ==========================================================
// Register map
`define AXI_AW 8
`define AXI_DW 32
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_IRQ_STAT 8'h08
`define OFF_IRQ_MASK 8'h0C
`define OFF_BURSTS 8'h10
`define RSP_OKAY 2'h0
`define RSP_SLVERR 2'h2

// Register selector codes.
`define SEL_CTRL 3'h0
`define SEL_STATUS 3'h1
`define SEL_IRQ_STAT 3'h2
`define SEL_IRQ_MASK 3'h3
`define SEL_BURSTS 3'h4
`define SEL_MISS 3'h7

// Control fields.
`define CTRL_W 3
`define CTRL_BURST 0
`define CTRL_ECC 1
`define CTRL_ADV 2
`define CTRL_INJ 3
`define CTRL_RST 3'h1

// Status fields.
`define ST_LINK 0
`define ST_BURST 1
`define ST_INJ 2
`define ST_SYNC_LO 8

// Interrupt fields.
`define IRQ_W 5
`define IRQ_CRC 0
`define IRQ_ALIGN 1
`define IRQ_OVF 2
`define IRQ_ECC_FIX 3
`define IRQ_ECC_BAD 4
`define IRQ_RST 5'h00

`define CNT_W 16

`endif

// file: sink_user_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "sink_port_defs.vh"

// ==========================================================
// User logic that consumes the received stream.
module sink_user_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rx_link_up,
    input wire logic rx_valid,
    input wire logic [`DATA_W-1:0] rx_data,
    input wire logic rx_burst_first,
    input wire logic rx_burst_last,
    input wire logic [`SYNC_W-1:0] rx_sync
);
    logic [`DATA_W+`SYNC_W+1:0] got[$];
    int dropped = 0;
    int closed = 0;
    always @(posedge aclk) begin
        if (aresetn && rx_valid && !rx_link_up)
            dropped <= dropped + 1;
        else if (aresetn && rx_valid) begin
            got.push_back({rx_burst_first, rx_burst_last, rx_sync, rx_data});
            if (rx_burst_last)
                closed <= closed + 1;
        end
    end
endmodule
`default_nettype wire

// file: stream_link_sink_port.v
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sink_port_defs.vh"

// Notes on behaviour
// - An 8-bit sync output carries the partner's sync field with the data.
// - At burst end sync gives invalid word count; zero with one lane.
// - Sync is never used for channelization or flow control.
// - Receive valid is high in each cycle with a valid data word.
// - Burst mode: first marker goes with a burst's first word.
// - Continuous mode: first marker goes once, with the first data word; the code also marks each word that follows a last marker.
// - Burst mode: last marker goes with a burst's last word.
// - Error vector is lanes+5 bits: CRC per lane, align, zero, overflow.
// - With ECC on, bit lanes+4 flags an uncorrectable FIFO upset; the code holds it low while the CTRL_ADV bit is set.
// - With ECC on, bit lanes+3 flags a corrected FIFO upset; the code holds it low while the CTRL_ADV bit is set.
// - Error-injection input corrupts the transmitted CRC so the receiver sees it.
// - Receive data is 64 bits per lane and carries the delivered stream.
module stream_link_sink_port (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire [`AXI_AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [`AXI_DW-1:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`AXI_AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [`AXI_DW-1:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire lk_up,
    input wire lk_valid,
    input wire [`DATA_W-1:0] lk_data,
    input wire lk_first,
    input wire lk_last,
    input wire [`SYNC_W-1:0] lk_sync,
    input wire [`LANES-1:0] lk_crc_err,
    input wire lk_align_lost,
    input wire fifo_overflow,
    input wire ecc_fixed,
    input wire ecc_bad,
    input wire crc_error_inject,
    input wire tx_crc_valid,
    input wire [`CRC_W-1:0] tx_crc_in,
    output wire tx_crc_out_valid,
    output wire [`CRC_W-1:0] tx_crc_out,
    output reg rx_link_up,
    output reg rx_valid,
    output reg [`DATA_W-1:0] rx_data,
    output reg rx_burst_first,
    output reg rx_burst_last,
    output reg [`SYNC_W-1:0] rx_sync,
    output reg [`ERR_W-1:0] rx_error,
    output wire irq
);

// ==========================================================
// Functions
function [2:0] reg_decode;
    input [`AXI_AW-1:0] a;
    begin
        case (a)
            `OFF_CTRL: reg_decode = `SEL_CTRL;
            `OFF_STATUS: reg_decode = `SEL_STATUS;
            `OFF_IRQ_STAT: reg_decode = `SEL_IRQ_STAT;
            `OFF_IRQ_MASK: reg_decode = `SEL_IRQ_MASK;
            `OFF_BURSTS: reg_decode = `SEL_BURSTS;
            default: reg_decode = `SEL_MISS;
        endcase
    end
endfunction

// Merges a masked byte write into a narrow field.
function [7:0] byte_merge;
    input [7:0] old;
    input [7:0] new_val;
    input en;
    begin
        byte_merge = en ? new_val : old;
    end
endfunction

// ==========================================================
// State
localparam [2:0] S_DOWN = 3'b001;
localparam [2:0] S_IDLE = 3'b010;
localparam [2:0] S_BURST = 3'b100;

reg [2:0] state_ff;
reg [2:0] nxt_state;
reg first_now;
reg last_now;

reg [`CTRL_W-1:0] ctrl_ff;
reg inj_pulse_ff;
reg [`IRQ_W-1:0] irq_stat_ff;
reg [`IRQ_W-1:0] irq_mask_ff;
reg [`CNT_W-1:0] bursts_ff;
reg [`SYNC_W-1:0] end_sync_ff;

reg aw_held_ff;
reg [`AXI_AW-1:0] aw_addr_ff;
reg w_held_ff;
reg [`AXI_DW-1:0] w_data_ff;
reg [3:0] w_strb_ff;

wire burst_mode;
wire ecc_on;
wire adv_clk;
wire wr_fire;
wire [2:0] wr_sel;
wire [2:0] rd_sel;
wire inject_pending;
wire [`IRQ_W-1:0] irq_events;
wire [`SYNC_W-1:0] sync_value;
wire [7:0] irq_clear;
wire [7:0] ctrl_new;
wire [7:0] mask_new;

assign burst_mode = ctrl_ff[`CTRL_BURST];
assign ecc_on = ctrl_ff[`CTRL_ECC];
assign adv_clk = ctrl_ff[`CTRL_ADV];

// ==========================================================
// Stream framing
always @* begin
    nxt_state = state_ff;
    first_now = 1'b0;
    last_now = 1'b0;
    case (state_ff)
        S_DOWN, S_IDLE: begin
            // A word that arrives as the link comes up is framed like any other.
            nxt_state = S_IDLE;
            if (lk_valid) begin
                if (burst_mode) begin
                    first_now = lk_first;
                    last_now = lk_first & lk_last;
                    if (lk_first && !lk_last) begin
                        nxt_state = S_BURST;
                    end
                end else begin
                    // Any word outside a burst starts one, which runs until a word with last.
                    first_now = 1'b1;
                    last_now = lk_last;
                    if (!lk_last) begin
                        nxt_state = S_BURST;
                    end
                end
            end
        end
        S_BURST: begin
            if (lk_valid && lk_last) begin
                last_now = 1'b1;
                nxt_state = S_IDLE;
            end
        end
        default: begin
            nxt_state = S_DOWN;
        end
    endcase
    if (!lk_up) begin
        nxt_state = S_DOWN;
        first_now = 1'b0;
        last_now = 1'b0;
    end
end

// Sync follows the partner; only its end-of-burst value is forced in one lane.
assign sync_value = (last_now && (`LANES == 1)) ? {`SYNC_W{1'b0}} : lk_sync;

always @(posedge aclk) begin
    if (!aresetn) begin
        state_ff <= S_DOWN;
        rx_link_up <= 1'b0;
        rx_valid <= 1'b0;
        rx_data <= {`DATA_W{1'b0}};
        rx_burst_first <= 1'b0;
        rx_burst_last <= 1'b0;
        rx_sync <= {`SYNC_W{1'b0}};
        rx_error <= {`ERR_W{1'b0}};
        end_sync_ff <= {`SYNC_W{1'b0}};
    end else if (ce) begin
        // All delivered outputs are registered on the one block clock.
        state_ff <= nxt_state;
        rx_link_up <= lk_up;
        rx_valid <= lk_valid;
        rx_data <= lk_data;
        rx_burst_first <= lk_valid & first_now;
        rx_burst_last <= lk_valid & last_now;
        // Sync is reported only; no flow or channel decision reads it.
        rx_sync <= sync_value;
        if (lk_valid && last_now) begin
            end_sync_ff <= sync_value;
        end
        rx_error[`LANES-1:0] <= lk_crc_err;
        rx_error[`ERR_ALIGN] <= lk_align_lost;
        rx_error[`ERR_ZERO] <= 1'b0;
        rx_error[`ERR_OVF] <= fifo_overflow & ~adv_clk;
        rx_error[`ERR_ECC_FIX] <= ecc_fixed & ecc_on & ~adv_clk;
        rx_error[`ERR_ECC_BAD] <= ecc_bad & ecc_on & ~adv_clk;
    end
end

// ==========================================================
// CRC error injection toward the transmitter
crc_fault_inject u_inject (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .inject_pin(crc_error_inject),
    .inject_sw(inj_pulse_ff),
    .tx_crc_valid(tx_crc_valid),
    .tx_crc_in(tx_crc_in),
    .tx_crc_out_valid(tx_crc_out_valid),
    .tx_crc_out(tx_crc_out),
    .inject_pending(inject_pending)
);

// ==========================================================
// Interrupts
assign irq_events[`IRQ_CRC] = |rx_error[`LANES-1:0];
assign irq_events[`IRQ_ALIGN] = rx_error[`ERR_ALIGN];
assign irq_events[`IRQ_OVF] = rx_error[`ERR_OVF];
assign irq_events[`IRQ_ECC_FIX] = rx_error[`ERR_ECC_FIX];
assign irq_events[`IRQ_ECC_BAD] = rx_error[`ERR_ECC_BAD];
assign irq = |(irq_stat_ff & irq_mask_ff);

// ==========================================================
// AXI4-Lite write channel
assign s_axi_awready = ~aw_held_ff & ~s_axi_bvalid;
assign s_axi_wready = ~w_held_ff & ~s_axi_bvalid;
assign wr_fire = aw_held_ff & w_held_ff & ~s_axi_bvalid;
assign wr_sel = reg_decode(aw_addr_ff);

assign irq_clear = (wr_fire && wr_sel == `SEL_IRQ_STAT && w_strb_ff[0]) ? w_data_ff[7:0] : 8'h00;
assign ctrl_new = byte_merge({5'h00, ctrl_ff}, w_data_ff[7:0], w_strb_ff[0]);
assign mask_new = byte_merge({3'h0, irq_mask_ff}, w_data_ff[7:0], w_strb_ff[0]);

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held_ff <= 1'b0;
        aw_addr_ff <= {`AXI_AW{1'b0}};
        w_held_ff <= 1'b0;
        w_data_ff <= {`AXI_DW{1'b0}};
        w_strb_ff <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RSP_OKAY;
        ctrl_ff <= `CTRL_RST;
        inj_pulse_ff <= 1'b0;
        irq_mask_ff <= `IRQ_RST;
        irq_stat_ff <= `IRQ_RST;
        bursts_ff <= {`CNT_W{1'b0}};
    end else if (ce) begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
        end
        inj_pulse_ff <= 1'b0;
        if (wr_fire) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == `SEL_MISS) ? `RSP_SLVERR : `RSP_OKAY;
            if (wr_sel == `SEL_CTRL) begin
                ctrl_ff <= ctrl_new[`CTRL_W-1:0];
                inj_pulse_ff <= w_strb_ff[0] & w_data_ff[`CTRL_INJ];
            end
            if (wr_sel == `SEL_IRQ_MASK) begin
                irq_mask_ff <= mask_new[`IRQ_W-1:0];
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        // A new event wins over a clear in the same cycle.
        irq_stat_ff <= (irq_stat_ff & ~irq_clear[`IRQ_W-1:0]) | irq_events;
        if (rx_burst_last) begin
            bursts_ff <= bursts_ff + 1'b1;
        end
    end
end

// ==========================================================
// AXI4-Lite read channel
assign s_axi_arready = ~s_axi_rvalid;
assign rd_sel = reg_decode(s_axi_araddr);

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= {`AXI_DW{1'b0}};
        s_axi_rresp <= `RSP_OKAY;
    end else if (ce) begin
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RSP_OKAY;
            s_axi_rdata <= {`AXI_DW{1'b0}};
            case (rd_sel)
                `SEL_CTRL: begin
                    s_axi_rdata[`CTRL_W-1:0] <= ctrl_ff;
                end
                `SEL_STATUS: begin
                    s_axi_rdata[`ST_LINK] <= rx_link_up;
                    s_axi_rdata[`ST_BURST] <= (state_ff == S_BURST);
                    s_axi_rdata[`ST_INJ] <= inject_pending;
                    s_axi_rdata[`ST_SYNC_LO+`SYNC_W-1:`ST_SYNC_LO] <= end_sync_ff;
                end
                `SEL_IRQ_STAT: begin
                    s_axi_rdata[`IRQ_W-1:0] <= irq_stat_ff;
                end
                `SEL_IRQ_MASK: begin
                    s_axi_rdata[`IRQ_W-1:0] <= irq_mask_ff;
                end
                `SEL_BURSTS: begin
                    s_axi_rdata[`CNT_W-1:0] <= bursts_ff;
                end
                default: begin
                    s_axi_rresp <= `RSP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule

`default_nettype wire

// file: stream_link_sink_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "sink_port_defs.vh"

// ==========================================================
// Port checks for the receive side and the transmit CRC path.
module sink_port_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic lk_valid,
    input wire logic [`DATA_W-1:0] lk_data,
    input wire logic [`SYNC_W-1:0] lk_sync,
    input wire logic [`LANES-1:0] lk_crc_err,
    input wire logic lk_align_lost,
    input wire logic fifo_overflow,
    input wire logic ecc_fixed,
    input wire logic tx_crc_valid,
    input wire logic [`CRC_W-1:0] tx_crc_in,
    input wire logic tx_crc_out_valid,
    input wire logic [`CRC_W-1:0] tx_crc_out,
    input wire logic rx_link_up,
    input wire logic rx_valid,
    input wire logic [`DATA_W-1:0] rx_data,
    input wire logic rx_burst_first,
    input wire logic rx_burst_last,
    input wire logic [`SYNC_W-1:0] rx_sync,
    input wire logic [`ERR_W-1:0] rx_error,
    input wire logic irq
);
    // Outputs seen at an edge are fresh only if the edge before was out of reset with the clock enabled.
    reg live_ff;
    reg in_burst_ff;
    always @(posedge aclk) begin
        live_ff <= aresetn && ce;
        if (!aresetn || !rx_link_up)
            in_burst_ff <= 1'h0;
        else if (live_ff && rx_valid)
            in_burst_ff <= (in_burst_ff || rx_burst_first) && !rx_burst_last;
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_valid_delay: assert property (live_ff |-> rx_valid == $past(lk_valid))
        else $error("receive valid lag wrong");
    a_data_delay: assert property (live_ff && rx_valid |-> rx_data == $past(lk_data))
        else $error("receive data wrong");
    a_sync_delay: assert property (live_ff |-> rx_sync == $past(lk_sync))
        else $error("sync output wrong");
    a_first_once: assert property (live_ff && rx_burst_first |-> rx_valid && !in_burst_ff)
        else $error("first marker inside a burst");
    a_last_inside: assert property (live_ff && rx_burst_last |-> rx_valid && (in_burst_ff || rx_burst_first))
        else $error("last marker outside a burst");
    a_err_low: assert property (live_ff |-> rx_error[`ERR_ZERO:0] == {1'h0, $past(lk_align_lost), $past(lk_crc_err)})
        else $error("crc or align bits wrong");
    a_ovf_cause: assert property (live_ff && rx_error[`ERR_OVF] |-> $past(fifo_overflow))
        else $error("overflow bit without cause");
    a_ecc_fix_cause: assert property (live_ff && rx_error[`ERR_ECC_FIX] |-> $past(ecc_fixed))
        else $error("corrected bit without cause");
    a_crc_pass: assert property (live_ff && $past(tx_crc_valid) |->
        tx_crc_out_valid && (tx_crc_out == $past(tx_crc_in) || tx_crc_out == ~$past(tx_crc_in)))
        else $error("transmit crc not passed");
    c_single_burst: cover property (rx_burst_first && rx_burst_last);
    c_inject: cover property (live_ff && $past(tx_crc_valid) && tx_crc_out == ~$past(tx_crc_in));
    c_irq: cover property (irq);
endmodule

bind stream_link_sink_port sink_port_checker chk (.*);
`default_nettype wire

// file: stream_link_sink_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sink_port_defs.vh"

// ==========================================================
// Self-checking bench.
module stream_link_sink_port_tb;
    localparam int WW = `DATA_W + `SYNC_W + 2;
    typedef logic [WW-1:0] v_t;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [`AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [`AXI_DW-1:0] s_axi_wdata = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic lk_up = 1'h0, lk_valid = 1'h0, lk_first = 1'h0, lk_last = 1'h0, crc_error_inject = 1'h0, tx_crc_valid = 1'h0;
    logic [`DATA_W-1:0] lk_data = '0;
    logic [7:0] lk_sync = 8'h00;
    logic [5:0] evt = 6'h00;
    logic [31:0] tx_crc_in = 32'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_crc_out_valid, irq;
    wire rx_link_up, rx_valid, rx_burst_first, rx_burst_last;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, tx_crc_out;
    wire [`DATA_W-1:0] rx_data;
    wire [7:0] rx_sync;
    wire [`ERR_W-1:0] rx_error;
    int err_count = 0;
    int compares = 0;
    v_t exp_q[$];
    logic [5:0] evs [5] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20};

    stream_link_sink_port dut (.*, .ce(1'h1), .s_axi_wstrb(4'hF), .lk_crc_err(evt[1:0]), .lk_align_lost(evt[2]),
        .fifo_overflow(evt[3]), .ecc_fixed(evt[4]), .ecc_bad(evt[5]));
    sink_user_model sink (.*);

    initial forever #5 aclk = ~aclk;

    task conclude();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task check(input v_t seen, input v_t want);
        compares++;
        if (seen !== want) begin
            err_count++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, want);
        end
    endtask

    task give_up();
        err_count++;
        $display("[ERR] %0t bus wait ran out", $time);
        conclude();
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw;
        logic w;
        aw = 1'h1;
        w = 1'h1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int n = 0; n <= 50; n++) begin
            if (n == 50)
                give_up();
            @(posedge aclk);
            if (aw && s_axi_awready === 1'h1) begin
                aw = 1'h0;
                s_axi_awvalid <= 1'h0;
            end
            if (w && s_axi_wready === 1'h1) begin
                w = 1'h0;
                s_axi_wvalid <= 1'h0;
            end
            if (s_axi_bvalid === 1'h1) begin
                s_axi_bready <= 1'h0;
                check(v_t'(s_axi_bresp), v_t'(r));
                break;
            end
        end
        @(posedge aclk);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (int n = 0; n <= 50; n++) begin
            if (n == 50)
                give_up();
            @(posedge aclk);
            if (s_axi_arready === 1'h1)
                s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) begin
                s_axi_rready <= 1'h0;
                check(v_t'({s_axi_rresp, s_axi_rdata}), v_t'({r, d}));
                break;
            end
        end
        @(posedge aclk);
    endtask

    // Words offered while the link is down are not expected at the user side.
    task push(input logic v, f, l, input logic [7:0] s, input logic [15:0] k, input logic ef, el);
        lk_valid <= v;
        lk_first <= f;
        lk_last <= l;
        lk_sync <= s;
        lk_data <= {{4{k}}, {4{~k}}};
        @(posedge aclk);
        // Link-up is judged as the design sampled it at this edge.
        if (v && lk_up === 1'h1)
            exp_q.push_back({ef, el, s, {4{k}}, {4{~k}}});
    endtask

    task drain();
        push(1'h0, 1'h0, 1'h0, 8'h00, 16'h0000, 1'h0, 1'h0);
        repeat (2) @(posedge aclk);
        check(v_t'(sink.got.size()), v_t'(exp_q.size()));
        while (exp_q.size() > 0 && sink.got.size() > 0)
            check(sink.got.pop_front(), exp_q.pop_front());
        exp_q.delete();
        sink.got.delete();
    endtask

    task pulse(input logic [5:0] e, input logic [6:0] x);
        evt <= e;
        @(posedge aclk);
        evt <= 6'h00;
        @(posedge aclk);
        check(v_t'(rx_error), v_t'(x));
    endtask

    task crc(input logic [31:0] v, input logic [31:0] x);
        tx_crc_valid <= 1'h1;
        tx_crc_in <= v;
        @(posedge aclk);
        tx_crc_valid <= 1'h0;
        @(posedge aclk);
        check(v_t'({tx_crc_out_valid, tx_crc_out}), v_t'({1'h1, x}));
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        lk_up <= 1'h1;
        rd(`OFF_CTRL, 32'h1, `RSP_OKAY);
        rd(`OFF_IRQ_MASK, 32'h0, `RSP_OKAY);
        rd(8'h14, 32'h0, `RSP_SLVERR);
        wr(8'h18, 32'hF, `RSP_SLVERR);
        push(1'h1, 1'h1, 1'h0, 8'h11, 16'h0001, 1'h1, 1'h0);
        push(1'h1, 1'h1, 1'h0, 8'h12, 16'h0002, 1'h0, 1'h0);
        push(1'h1, 1'h0, 1'h1, 8'h13, 16'h0003, 1'h0, 1'h1);
        push(1'h1, 1'h1, 1'h1, 8'h21, 16'h0004, 1'h1, 1'h1);
        push(1'h1, 1'h0, 1'h1, 8'h30, 16'h0005, 1'h0, 1'h0);
        drain();
        rd(`OFF_BURSTS, 32'h2, `RSP_OKAY);
        rd(`OFF_STATUS, 32'h2101, `RSP_OKAY);
        wr(`OFF_CTRL, 32'h0, `RSP_OKAY);
        push(1'h1, 1'h0, 1'h0, 8'h41, 16'h0006, 1'h1, 1'h0);
        push(1'h1, 1'h1, 1'h0, 8'h42, 16'h0007, 1'h0, 1'h0);
        push(1'h1, 1'h0, 1'h1, 8'h43, 16'h0008, 1'h0, 1'h1);
        push(1'h1, 1'h0, 1'h0, 8'h44, 16'h0009, 1'h1, 1'h0);
        lk_up <= 1'h0;
        push(1'h0, 1'h0, 1'h0, 8'h00, 16'h0000, 1'h0, 1'h0);
        push(1'h1, 1'h1, 1'h0, 8'h50, 16'h000A, 1'h0, 1'h0);
        lk_up <= 1'h1;
        push(1'h1, 1'h0, 1'h0, 8'h51, 16'h000B, 1'h1, 1'h0);
        drain();
        check(v_t'(sink.dropped), v_t'(1));
        wr(`OFF_CTRL, 32'h3, `RSP_OKAY);
        wr(`OFF_IRQ_MASK, 32'h1F, `RSP_OKAY);
        for (int i = 0; i < 5; i++) begin
            pulse(evs[i], {evs[i][5:3], 1'h0, evs[i][2:0]});
            rd(`OFF_IRQ_STAT, 32'h1 << i, `RSP_OKAY);
            check(v_t'(irq), v_t'(1'h1));
            wr(`OFF_IRQ_STAT, 32'h1F, `RSP_OKAY);
            check(v_t'(irq), v_t'(1'h0));
        end
        wr(`OFF_IRQ_MASK, 32'h0, `RSP_OKAY);
        pulse(6'h04, 7'h04);
        rd(`OFF_IRQ_STAT, 32'h2, `RSP_OKAY);
        check(v_t'(irq), v_t'(1'h0));
        wr(`OFF_CTRL, 32'h1, `RSP_OKAY);
        pulse(6'h30, 7'h00);
        wr(`OFF_CTRL, 32'h7, `RSP_OKAY);
        pulse(6'h39, 7'h01);
        wr(`OFF_CTRL, 32'h1, `RSP_OKAY);
        crc_error_inject <= 1'h1;
        repeat (4) @(posedge aclk);
        crc(32'hA5A50F0F, 32'h5A5AF0F0);
        crc_error_inject <= 1'h0;
        crc(32'h12345678, 32'h12345678);
        wr(`OFF_CTRL, 32'h9, `RSP_OKAY);
        rd(`OFF_CTRL, 32'h1, `RSP_OKAY);
        crc(32'h0000FFFF, 32'hFFFF0000);
        conclude();
    end
endmodule
`default_nettype wire
